//--- logic/pems_pkg.sv
package pems_pkg;

  // link timing at a 10 MHz system clock
  localparam int SYS_CLK_HZ = 10_000_000;
  localparam int READY_LOW_NS = 15_000;
  localparam int READY_LOW_CYC = (READY_LOW_NS * (SYS_CLK_HZ / 1_000_000)) / 1000;
  localparam int SYNC_STAGES = 3;

  // command opcodes and lengths
  localparam logic [3:0] OPC_ERASE_ROWS = 4'h9;
  localparam logic [3:0] OPC_BLANK_QUERY = 4'ha;
  localparam logic [3:0] OPC_VERSION_QUERY = 4'hb;
  localparam logic [11:0] LEN_ERASE_ROWS = 12'h003;
  localparam logic [11:0] LEN_BLANK_QUERY = 12'h003;

  // response fields
  localparam logic [3:0] RESP_PASS = 4'h1;
  localparam logic [3:0] RESP_REJECT = 4'h2;
  localparam logic [15:0] RESP_LEN = 16'h0002;
  localparam logic [7:0] QE_OK = 8'h00;
  localparam logic [7:0] QE_VERIFY = 8'h01;
  localparam logic [7:0] QE_OTHER = 8'h02;
  localparam logic [7:0] QE_BLANK = 8'hf0;
  localparam logic [7:0] QE_NOT_BLANK = 8'h0f;
  // version byte, value arbitrary
  localparam logic [7:0] EXEC_VERSION = 8'h10;

  // memory map
  localparam logic [23:0] ROW_STRIDE = 24'h000040;
  localparam logic [23:0] WORD_STRIDE = 24'h000002;
  localparam logic [23:0] CODE_START = 24'h000000;
  localparam logic [23:0] DATA_START = 24'h7ffffe;
  localparam logic [23:0] PROT_BASE = 24'hf80000;
  localparam logic [23:0] ERASED_WORD = 24'hffffff;
  localparam logic [15:0] ERASED_DATA = 16'hffff;

  typedef enum logic [2:0] {ST_HDR, ST_ARGS, ST_BUSY, ST_READY, ST_SEND} pems_state_t;
  typedef enum logic [2:0] {JOB_IDLE, JOB_ERASE, JOB_CODE, JOB_DATA, JOB_DONE} pems_job_t;
  typedef enum logic {MEM_READ, MEM_ERASE_ROW} pems_mem_op_t;

  typedef struct packed {
    logic [3:0] opc;
    logic [11:0] len;
  } pems_hdr_t;

  typedef struct packed {
    logic valid;
    pems_mem_op_t op;
    logic [23:0] addr;
  } pems_mem_req_t;

  typedef struct packed {
    logic ack;
    logic err;
    logic [23:0] rdata;
  } pems_mem_rsp_t;

  // three link words to two instructions; odd count leaves w2 unused
  function automatic logic [47:0] pems_unpack_pair(input logic [15:0] w0,
                                                   input logic [15:0] w1,
                                                   input logic [15:0] w2);
    pems_unpack_pair = {w1[15:8], w2, w1[7:0], w0};
  endfunction

  function automatic logic pems_supported(input logic [3:0] opc);
    pems_supported = (opc == OPC_ERASE_ROWS) || (opc == OPC_BLANK_QUERY) ||
                     (opc == OPC_VERSION_QUERY);
  endfunction

endpackage

//--- logic/pems_pin_sync.sv
`timescale 1ns/1ps
module pems_pin_sync
  import pems_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic raw,
  output logic level,
  output logic rise,
  output logic fall
);

  logic [SYNC_STAGES-1:0] sync_ff;
  logic lvl_ff;

  // three-stage capture of an asynchronous pin
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync_ff <= '0;
    end else begin
      sync_ff <= {sync_ff[SYNC_STAGES-2:0], raw};
    end
  end

  // accepted level moves only when stages two and three agree
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lvl_ff <= 1'b0;
    end else if (sync_ff[1] == sync_ff[2]) begin
      lvl_ff <= sync_ff[2];
    end
  end

  assign level = (sync_ff[1] == sync_ff[2]) ? sync_ff[2] : lvl_ff;
  assign rise = sync_ff[1] & sync_ff[2] & ~lvl_ff;
  assign fall = ~sync_ff[1] & ~sync_ff[2] & lvl_ff;

endmodule // pems_pin_sync

//--- logic/pems_cmd_link.sv
`timescale 1ns/1ps
module pems_cmd_link
  import pems_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic prog_clock_pin,
  input wire logic prog_data_pin_in,
  output logic prog_data_pin_out,
  output logic prog_data_pin_oe_n,
  output pems_mem_req_t mem_req,
  input wire pems_mem_rsp_t mem_rsp
);

  pems_state_t state_ff;
  pems_job_t job_ff;
  pems_hdr_t hdr_ff;
  logic [15:0] shift_ff;
  logic [3:0] bit_cnt_ff;
  logic [11:0] word_cnt_ff;
  logic [15:0] arg1_ff;
  logic [15:0] arg2_ff;
  logic [7:0] timer_ff;
  logic [31:0] tx_ff;
  logic [4:0] tx_cnt_ff;
  logic armed_ff;
  logic [15:0] count_ff;
  logic [23:0] addr_ff;
  logic [7:0] qe_ff;
  logic blank_ok_ff;
  pems_mem_req_t req_ff;
  logic dout_ff;
  logic oe_n_ff;
  logic clk_rise;
  logic clk_fall;
  logic din;
  logic word_done;
  logic [15:0] rx_word;
  logic [15:0] resp_word;

  // link clock is only an input, sampled and edge-detected here
  pems_pin_sync u_clk_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .raw(prog_clock_pin),
    .level(),
    .rise(clk_rise),
    .fall(clk_fall)
  );

  pems_pin_sync u_data_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .raw(prog_data_pin_in),
    .level(din),
    .rise(),
    .fall()
  );

  // word assembly, most significant bit first, on rising edges
  assign word_done = clk_rise && (bit_cnt_ff == 4'hf);
  assign rx_word = {shift_ff[14:0], din};

  // first response word: status nibble, command opcode, code byte
  always_comb begin
    resp_word = {RESP_REJECT, hdr_ff.opc, QE_OTHER};
    case (hdr_ff.opc)
      OPC_ERASE_ROWS: resp_word = {RESP_PASS, hdr_ff.opc, qe_ff};
      OPC_BLANK_QUERY: begin
        resp_word = {RESP_PASS, hdr_ff.opc, blank_ok_ff ? QE_BLANK : QE_NOT_BLANK};
      end
      OPC_VERSION_QUERY: resp_word = {RESP_PASS, hdr_ff.opc, EXEC_VERSION};
      default: resp_word = {RESP_REJECT, hdr_ff.opc, QE_OTHER};
    endcase
  end

  // receive shifter, idle outside the command phase
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      shift_ff <= 16'h0000;
      bit_cnt_ff <= 4'h0;
    end else if (state_ff == ST_HDR || state_ff == ST_ARGS) begin
      if (clk_rise) begin
        shift_ff <= rx_word;
        bit_cnt_ff <= bit_cnt_ff + 4'h1;
      end
    end else begin
      bit_cnt_ff <= 4'h0;
    end
  end

  // link sequencer: command in, busy, ready pulse, response out
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_ff <= ST_HDR;
      hdr_ff <= '0;
      word_cnt_ff <= 12'h000;
      arg1_ff <= 16'h0000;
      arg2_ff <= 16'h0000;
      timer_ff <= 8'h00;
      tx_ff <= 32'h0000_0000;
      tx_cnt_ff <= 5'h00;
      armed_ff <= 1'b0;
    end else begin
      case (state_ff)
        ST_HDR: begin
          if (word_done) begin
            hdr_ff <= rx_word;
            word_cnt_ff <= 12'h001;
            if (rx_word[11:0] <= 12'h001) begin
              state_ff <= ST_BUSY;
            end else begin
              state_ff <= ST_ARGS;
            end
          end
        end
        ST_ARGS: begin
          if (word_done) begin
            // argument words taken as sent, no range checks
            if (word_cnt_ff == 12'h001) begin
              arg1_ff <= rx_word;
            end
            if (word_cnt_ff == 12'h002) begin
              arg2_ff <= rx_word;
            end
            word_cnt_ff <= word_cnt_ff + 12'h001;
            if (word_cnt_ff + 12'h001 == hdr_ff.len) begin
              state_ff <= ST_BUSY;
            end
          end
        end
        ST_BUSY: begin
          if (job_ff == JOB_DONE) begin
            state_ff <= ST_READY;
            timer_ff <= 8'h00;
            tx_ff <= {resp_word, RESP_LEN};
          end
        end
        ST_READY: begin
          timer_ff <= timer_ff + 8'h01;
          if (timer_ff == 8'(READY_LOW_CYC - 1)) begin
            state_ff <= ST_SEND;
            tx_cnt_ff <= 5'h00;
            armed_ff <= 1'b0;
          end
        end
        ST_SEND: begin
          // bit changes on the falling edge after each sampled bit
          if (clk_rise) begin
            tx_cnt_ff <= tx_cnt_ff + 5'h01;
            armed_ff <= 1'b1;
            if (tx_cnt_ff == 5'h1f) begin
              state_ff <= ST_HDR;
            end
          end else if (clk_fall && armed_ff) begin
            tx_ff <= {tx_ff[30:0], 1'b0};
            armed_ff <= 1'b0;
          end
        end
        default: state_ff <= ST_HDR;
      endcase
    end
  end

  // command execution against the memory port
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      job_ff <= JOB_IDLE;
      req_ff <= '0;
      count_ff <= 16'h0000;
      addr_ff <= 24'h000000;
      qe_ff <= QE_OK;
      blank_ok_ff <= 1'b1;
    end else begin
      case (job_ff)
        JOB_IDLE: begin
          if (state_ff == ST_BUSY) begin
            qe_ff <= QE_OK;
            blank_ok_ff <= 1'b1;
            case (hdr_ff.opc)
              OPC_ERASE_ROWS: begin
                job_ff <= JOB_ERASE;
                count_ff <= {8'h00, arg1_ff[15:8]};
                addr_ff <= {arg1_ff[7:0], arg2_ff};
              end
              OPC_BLANK_QUERY: begin
                job_ff <= JOB_CODE;
                count_ff <= arg1_ff;
                addr_ff <= CODE_START;
              end
              default: job_ff <= JOB_DONE;
            endcase
          end
        end
        JOB_ERASE: begin
          if (!req_ff.valid) begin
            if (count_ff == 16'h0000) begin
              job_ff <= JOB_DONE;
            end else if (addr_ff >= PROT_BASE) begin
              qe_ff <= QE_OTHER;
              job_ff <= JOB_DONE;
            end else begin
              req_ff <= '{valid: 1'b1, op: MEM_ERASE_ROW, addr: addr_ff};
            end
          end else if (mem_rsp.ack) begin
            req_ff.valid <= 1'b0;
            if (mem_rsp.err) begin
              qe_ff <= QE_OTHER;
              job_ff <= JOB_DONE;
            end else begin
              count_ff <= count_ff - 16'h0001;
              addr_ff <= addr_ff + ROW_STRIDE;
            end
          end
        end
        JOB_CODE: begin
          if (!req_ff.valid) begin
            if (count_ff == 16'h0000) begin
              job_ff <= JOB_DATA;
              count_ff <= {4'h0, arg2_ff[11:0]};
              addr_ff <= DATA_START;
            end else begin
              req_ff <= '{valid: 1'b1, op: MEM_READ, addr: addr_ff};
            end
          end else if (mem_rsp.ack) begin
            req_ff.valid <= 1'b0;
            if (mem_rsp.err || mem_rsp.rdata != ERASED_WORD) begin
              blank_ok_ff <= 1'b0;
            end
            count_ff <= count_ff - 16'h0001;
            addr_ff <= addr_ff + WORD_STRIDE;
          end
        end
        JOB_DATA: begin
          // only the two walked regions are read, never configuration
          if (!req_ff.valid) begin
            if (count_ff == 16'h0000) begin
              job_ff <= JOB_DONE;
            end else begin
              req_ff <= '{valid: 1'b1, op: MEM_READ, addr: addr_ff};
            end
          end else if (mem_rsp.ack) begin
            req_ff.valid <= 1'b0;
            if (mem_rsp.err || mem_rsp.rdata[15:0] != ERASED_DATA) begin
              blank_ok_ff <= 1'b0;
            end
            count_ff <= count_ff - 16'h0001;
            addr_ff <= addr_ff - WORD_STRIDE;
          end
        end
        JOB_DONE: begin
          if (state_ff != ST_BUSY) begin
            job_ff <= JOB_IDLE;
          end
        end
        default: job_ff <= JOB_IDLE;
      endcase
    end
  end

  // pin drive: released while receiving, high busy, low ready
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dout_ff <= 1'b1;
      oe_n_ff <= 1'b1;
    end else begin
      case (state_ff)
        ST_BUSY: begin
          dout_ff <= 1'b1;
          oe_n_ff <= 1'b0;
        end
        ST_READY: begin
          dout_ff <= 1'b0;
          oe_n_ff <= 1'b0;
        end
        ST_SEND: begin
          dout_ff <= tx_ff[31];
          oe_n_ff <= 1'b0;
        end
        default: begin
          dout_ff <= 1'b1;
          oe_n_ff <= 1'b1;
        end
      endcase
    end
  end

  assign prog_data_pin_out = dout_ff;
  assign prog_data_pin_oe_n = oe_n_ff;
  assign mem_req = req_ff;

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence seq_ready_hold;
    (!prog_data_pin_oe_n && !prog_data_pin_out)[*8];
  endsequence

  sequence seq_into_send;
    ##148 (state_ff == ST_READY) ##1 (state_ff == ST_SEND);
  endsequence

  property p_ready_pulse;
    $rose(state_ff == ST_READY) |=> seq_ready_hold and seq_into_send;
  endproperty

  a_busy_drives_high: assert property (
    (state_ff == ST_BUSY) |=> (!prog_data_pin_oe_n && prog_data_pin_out))
    else $error("data pin not driven high while busy");

  a_ready_pulse_len: assert property (p_ready_pulse)
    else $error("ready low pulse has wrong length");

  a_last_word_busy: assert property (
    (state_ff == ST_ARGS && word_done && word_cnt_ff + 12'h001 == hdr_ff.len)
    |=> (state_ff == ST_BUSY) ##1 (prog_data_pin_out && !prog_data_pin_oe_n))
    else $error("command end did not enter busy");

  a_erase_resp_word: assert property (
    ($rose(state_ff == ST_SEND) && hdr_ff.opc == OPC_ERASE_ROWS && qe_ff == QE_OK)
    |-> (tx_ff == {RESP_PASS, OPC_ERASE_ROWS, QE_OK, RESP_LEN}))
    else $error("row erase response word wrong");

  a_blank_resp_code: assert property (
    ($rose(state_ff == ST_SEND) && hdr_ff.opc == OPC_BLANK_QUERY)
    |-> (tx_ff[31:16] == {RESP_PASS, OPC_BLANK_QUERY,
                          blank_ok_ff ? QE_BLANK : QE_NOT_BLANK}) && tx_ff[15:0] == RESP_LEN)
    else $error("blank query response wrong");

  a_reject_unknown: assert property (
    ($rose(state_ff == ST_SEND) && !pems_supported(hdr_ff.opc))
    |-> (tx_ff[31:28] == RESP_REJECT))
    else $error("unsupported opcode not rejected");

  a_erase_protect: assert property (
    (req_ff.valid && req_ff.op == MEM_ERASE_ROW) |-> (req_ff.addr < PROT_BASE))
    else $error("erase reached protected region");

  a_blank_walk_start: assert property (
    (job_ff == JOB_CODE && $past(job_ff) == JOB_IDLE) |-> (addr_ff == CODE_START))
    else $error("code blank walk did not start at zero");

  a_one_response: assert property (
    (state_ff == ST_SEND && clk_rise && tx_cnt_ff == 5'h1f)
    |=> (state_ff == ST_HDR) ##1 prog_data_pin_oe_n)
    else $error("response did not end after two words");

  a_tx_on_fall: assert property (
    (state_ff == ST_SEND && $past(state_ff) == ST_SEND && tx_ff != $past(tx_ff))
    |-> $past(clk_fall))
    else $error("response bit changed away from falling edge");

endmodule // pems_cmd_link

//--- verif/pems_prog_model.sv
`timescale 1ns/1ps
// programmer side of the link: owns the clock, sends commands, reads answers
module pems_prog_model (
  input wire logic sys_clk,
  input wire logic line,
  output logic clk_pin,
  output logic drv_en,
  output logic drv_val
);
  // clock stands low and data line released between frames
  initial begin
    clk_pin = 1'b0;
    drv_en = 1'b0;
    drv_val = 1'b0;
  end

  // one 800 ns link period, rise in the middle
  task automatic pulse();
    repeat (4) @(posedge sys_clk);
    clk_pin <= 1'b1;
    repeat (4) @(posedge sys_clk);
    clk_pin <= 1'b0;
  endtask

  // whole command, msb first, bit changed while clock is low
  task automatic send_cmd(input logic [47:0] w, input int nw);
    @(posedge sys_clk);
    drv_en <= 1'b1;
    for (int i = 47; i > 47 - 16 * nw; i--) begin
      drv_val <= w[i];
      pulse();
    end
    drv_en <= 1'b0;
  endtask

  // waits for busy high, then ready low, then clocks out two words
  task automatic read_resp(output logic [31:0] r, output int hi, output int lo);
    hi = 0;
    lo = 0;
    r = '0;
    for (int i = 0; i < 200 && hi < 2; i++) begin
      @(posedge sys_clk);
      hi = line ? hi + 1 : 0;
    end
    for (int i = 0; i < 5000 && line; i++) @(posedge sys_clk);
    while (lo < 150 && !line) begin
      @(posedge sys_clk);
      lo++;
    end
    for (int i = 31; i >= 0; i--) begin
      repeat (4) @(posedge sys_clk);
      clk_pin <= 1'b1;
      repeat (2) @(posedge sys_clk);
      r[i] = line;
      repeat (2) @(posedge sys_clk);
      clk_pin <= 1'b0;
    end
    repeat (8) @(posedge sys_clk);
  endtask
endmodule // pems_prog_model

//--- verif/test_pems_cmd_link.sv
`timescale 1ns/1ps
module test_pems_cmd_link;
  import pems_pkg::*;

  typedef struct {
    logic [47:0] w;
    int nw;
    logic [15:0] code;
    int nreq;
    logic [23:0] a0;
    logic [23:0] alast;
  } pems_row_t;

  logic sys_clk;
  logic rst;
  logic prog_clock_pin;
  logic pd_line;
  logic dev_out;
  logic dev_oe_n;
  logic m_en;
  logic m_val;
  logic last_ff;
  pems_mem_req_t mem_req;
  pems_mem_rsp_t mem_rsp;
  logic [23:0] dirty_addr;
  logic mem_fail;
  logic [23:0] addr_q[$];
  pems_mem_op_t op_q[$];
  int bad_count;
  int n_compared;
  pems_row_t rows[6];

  // wire level; undriven line shows the inverse of its last driven level
  assign pd_line = !dev_oe_n ? dev_out : (m_en ? m_val : ~last_ff);

  pems_cmd_link pems_cmd_link_inst (
    .sys_clk(sys_clk),
    .rst(rst),
    .prog_clock_pin(prog_clock_pin),
    .prog_data_pin_in(pd_line),
    .prog_data_pin_out(dev_out),
    .prog_data_pin_oe_n(dev_oe_n),
    .mem_req(mem_req),
    .mem_rsp(mem_rsp)
  );

  pems_prog_model pems_prog_model_inst (
    .sys_clk(sys_clk),
    .line(pd_line),
    .clk_pin(prog_clock_pin),
    .drv_en(m_en),
    .drv_val(m_val)
  );

  // clock and time-zero values
  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    last_ff = 1'b0;
    mem_rsp = '0;
    dirty_addr = 24'h111111;
    mem_fail = 1'b0;
    bad_count = 0;
    n_compared = 0;
    forever #50 sys_clk = ~sys_clk;
  end

  // memory acks one cycle after a request and logs each taken address
  always @(posedge sys_clk) begin
    if (!dev_oe_n || m_en) last_ff <= pd_line;
    mem_rsp.ack <= mem_req.valid && !mem_rsp.ack;
    mem_rsp.err <= mem_fail;
    mem_rsp.rdata <= (mem_req.addr == dirty_addr) ? 24'h00a5a5 : 24'hffffff;
    if (mem_req.valid && mem_rsp.ack) begin
      addr_q.push_back(mem_req.addr);
      op_q.push_back(mem_req.op);
    end
  end

  task automatic check_v(input logic [23:0] e, input logic [23:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch at %0t: expected %h got %h", $time, e, g);
    end
  endtask

  task automatic check_i(input int e, input int g);
    n_compared++;
    if (g != e) begin
      bad_count++;
      $display("mismatch at %0t: expected %h got %h", $time, e, g);
    end
  endtask

  task automatic give_verdict();
    if (bad_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // one command and its answer, with the memory traffic it caused
  task automatic run(input pems_row_t c);
    logic [31:0] r;
    int hi;
    int lo;
    addr_q.delete();
    op_q.delete();
    pems_prog_model_inst.send_cmd(c.w, c.nw);
    pems_prog_model_inst.read_resp(r, hi, lo);
    check_v({8'h00, c.code}, {8'h00, r[31:16]});
    check_v({8'h00, RESP_LEN}, {8'h00, r[15:0]});
    check_i(2, hi);
    check_i(150, lo);
    if (c.nreq >= 0) begin
      check_i(c.nreq, addr_q.size());
    end
    if (c.nreq > 0) begin
      check_v(c.a0, addr_q[0]);
      check_v({23'h0, (c.w[47:44] == OPC_ERASE_ROWS)},
              {23'h0, op_q[0] == MEM_ERASE_ROW});
      check_v(c.alast, addr_q[c.nreq - 1]);
    end
  endtask

  // ordinary commands: erase, blank, version, unknown, protected, zero rows
  initial begin
    rows[0] = '{{16'h9003, 16'h0200, 16'h0080}, 3, 16'h1900, 2, 24'h80, 24'hc0};
    rows[1] = '{{16'ha003, 16'h0002, 16'h0002}, 3, 16'h1af0, 4, 24'h0, 24'h7ffffc};
    rows[2] = '{{16'hb001, 32'h0}, 1, {RESP_PASS, OPC_VERSION_QUERY, EXEC_VERSION}, 0, 0, 0};
    rows[3] = '{{16'h5002, 16'h1234, 16'h0}, 2, 16'h2502, 0, 0, 0};
    rows[4] = '{{16'h9003, 16'h01f8, 16'h0000}, 3, 16'h1902, 0, 0, 0};
    rows[5] = '{{16'h9003, 16'h0000, 16'h0100}, 3, 16'h1900, 0, 0, 0};
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    foreach (rows[i]) run(rows[i]);
    // dirty code word, then dirty data word with no code walk
    dirty_addr <= 24'h000002;
    run('{{16'ha003, 16'h0003, 16'h0000}, 3, 16'h1a0f, -1, 0, 0});
    dirty_addr <= 24'h7ffffe;
    run('{{16'ha003, 16'h0000, 16'h0001}, 3, 16'h1a0f, -1, 0, 0});
    // memory fault during erase
    dirty_addr <= 24'h111111;
    mem_fail <= 1'b1;
    run('{{16'h9003, 16'h0100, 16'h0040}, 3, 16'h1902, -1, 0, 0});
    mem_fail <= 1'b0;
    // reset while the answer is pending releases the line
    pems_prog_model_inst.send_cmd({16'h9003, 16'h0100, 16'h0040}, 3);
    repeat (20) @(posedge sys_clk);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    check_v(24'h1, {23'h0, dev_oe_n});
    check_v(24'h0, {23'h0, mem_req.valid});
    repeat (4) @(posedge sys_clk);
    run(rows[2]);
    give_verdict();
  end

  // watchdog over the whole sequence
  initial begin
    repeat (60000) @(posedge sys_clk);
    bad_count++;
    give_verdict();
  end
endmodule // test_pems_cmd_link
